// file: sim/hps_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module hps_asserts (
  // Clock and reset
  input wire logic       CORE_CLK,
  input wire logic       NRST,
  // Link
  input wire logic       port_select_n,
  input wire logic       data_strobe_a_n,
  input wire logic       data_strobe_b_n,
  input wire logic       addr_strobe_n,
  input wire logic [1:0] access_ctl,
  input wire logic [1:0] byte_enables_n,
  input wire logic       read_not_write,
  input wire logic       port_ready,
  input wire logic       dsp_to_host_irq
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  // Strobe as the device derives it
  wire logic go = !port_select_n && (data_strobe_a_n ^ data_strobe_b_n);
  sequence s_go; $rose(go); endsequence
  sequence s_busy; ##[2:6] !port_ready; endsequence
  a_strobe_busy: assert property (s_go |-> s_busy)
    else $error("ready did not drop after strobe");
  a_busy_cause: assert property ($fell(port_ready) |-> $past(go, 3))
    else $error("ready dropped without strobe");
  a_sel_forces_rdy: assert property (port_select_n [*4] |-> port_ready)
    else $error("ready low while deselected");
  a_sel_held: assert property ((data_strobe_a_n ^ data_strobe_b_n) |-> !port_select_n)
    else $error("strobe active without select");
  a_spare_high: assert property (data_strobe_b_n)
    else $error("unused strobe not high");
  a_release_rdy: assert property ($rose(data_strobe_a_n) |-> $past(port_ready))
    else $error("strobe released before ready");
  a_strobe_width: assert property ($fell(data_strobe_a_n) |=> !data_strobe_a_n [*7])
    else $error("strobe too short");
  a_sel_first: assert property ($fell(data_strobe_a_n) |-> $past(!port_select_n))
    else $error("strobe before select");
endmodule
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
  $display("FAIL at %0t: value mismatch", $time); end end
module tb;
  import hps_pkg::*;
  logic       core_clk = 1'b0;
  logic       nrst, req, rnw, mux, st3, acc_done, done, irq;
  logic [1:0] ctl, be;
  logic       acc_req, acc_inc, acc_rnw, acc_bad, req2, bad2;
  logic [1:0] acc_be_n;
  hps_sel_t   acc_sel;
  logic [6:0] exp_q[$];
  logic [31:0] rs = 32'h0001_1120;
  int         miscompares = 0;
  int         tests_run = 0;
  int         req2_cnt = 0;
  hps_if link();
  hps_if link2();
  always #4 core_clk = ~core_clk;
  hps_host u_hps_host (.CORE_CLK(core_clk), .NRST(nrst), .LINK(link), .REQ(req),
    .CTL(ctl), .BE_N(be), .RNW(rnw), .MUX_MODE(mux), .BUSY(), .DONE(done), .IRQ(irq));
  hps_dev u_hps_dev (.CORE_CLK(core_clk), .NRST(nrst), .LINK(link), .MUX_MODE(mux),
    .CPU_STATUS3_DSP_TO_HOST_IRQ(st3), .ACC_REQ(acc_req), .ACC_SEL(acc_sel), .ACC_INC(acc_inc),
    .ACC_RNW(acc_rnw), .ACC_BE_N(acc_be_n), .ACC_BE_BAD(acc_bad), .ACC_DONE(acc_done));
  // Second device faces the bench directly so it can see rule-breaking pins
  hps_dev u_hps_dev_b (.CORE_CLK(core_clk), .NRST(nrst), .LINK(link2), .MUX_MODE(1'b0),
    .CPU_STATUS3_DSP_TO_HOST_IRQ(1'b0), .ACC_REQ(req2), .ACC_SEL(), .ACC_INC(), .ACC_RNW(),
    .ACC_BE_N(), .ACC_BE_BAD(bad2), .ACC_DONE(1'b0));
  hps_asserts u_hps_asserts (.CORE_CLK(core_clk), .NRST(nrst),
    .port_select_n(link.port_select_n), .data_strobe_a_n(link.data_strobe_a_n),
    .data_strobe_b_n(link.data_strobe_b_n), .addr_strobe_n(link.addr_strobe_n),
    .access_ctl(link.access_ctl), .byte_enables_n(link.byte_enables_n),
    .read_not_write(link.read_not_write), .port_ready(link.port_ready),
    .dsp_to_host_irq(link.dsp_to_host_irq));
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  // Expected engine request; the host never puts the reserved pair on the pins
  function automatic logic [6:0] expect_of(logic m, logic [1:0] c, logic [1:0] b, logic r);
    hps_sel_t   s;
    logic [1:0] e;
    s = c[0] ? HPS_SEL_DATA : HPS_SEL_CTRL;
    if (m && c == 2'h2) s = HPS_SEL_ADDR;
    e = (b == HPS_BE_RSVD) ? HPS_BE_WORD : b;
    return {s, m && c == 2'h1, r, e, 1'b0};
  endfunction
  // Engine finishes each access after a random pause
  always begin
    @(posedge core_clk);
    if (acc_req === 1'b1) begin
      repeat (xs() % 4) @(posedge core_clk);
      acc_done <= 1'b1;
      @(posedge core_clk);
      acc_done <= 1'b0;
    end
  end
  // Oldest note is matched against each request as it appears
  always @(posedge core_clk) begin
    if (acc_req === 1'b1) `CHK({acc_sel, acc_inc, acc_rnw, acc_be_n, acc_bad}, exp_q.pop_front())
    if (req2 === 1'b1) req2_cnt++;
  end
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic send(input logic m, input logic [1:0] c, input logic [1:0] b);
    logic r;
    int   n;
    r = 1'(xs());
    n = 0;
    mux <= m;
    st3 <= 1'(xs() >> 3);
    ctl <= c;
    be <= b;
    rnw <= r;
    req <= 1'b1;
    exp_q.push_back(expect_of(m, c, b, r));
    @(posedge core_clk);
    req <= 1'b0;
    while (done !== 1'b1 && n < 300) begin
      @(negedge core_clk);
      n++;
    end
    `CHK(done, 1'b1)
    `CHK(irq, st3)
    @(posedge core_clk);
  endtask
  // Watchdog sized well above the expected run
  initial begin
    repeat (8000) @(posedge core_clk);
    miscompares++;
    close_out();
  end
  initial begin
    {nrst, req, rnw, mux, st3, acc_done, ctl, be} = '0;
    {link2.port_select_n, link2.data_strobe_a_n, link2.data_strobe_b_n} = 3'h7;
    {link2.addr_strobe_n, link2.access_ctl, link2.byte_enables_n} = 5'h13;
    link2.read_not_write = 1'b0;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    // Every mode, code and byte-enable pair, back to back
    for (int i = 0; i < 32; i++) send(i[4], i[1:0], i[3:2]);
    $display("test decode done");
    repeat (10) begin
      link2.data_strobe_a_n <= ~link2.data_strobe_a_n;
      @(posedge core_clk);
    end
    link2.port_select_n <= 1'b0;
    link2.addr_strobe_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    link2.addr_strobe_n <= 1'b1;
    repeat (8) @(negedge core_clk);
    `CHK(req2_cnt, 0)
    @(posedge core_clk);
    link2.data_strobe_b_n <= 1'b0;
    repeat (8) @(negedge core_clk);
    `CHK(req2_cnt, 1)
    `CHK(link2.port_ready, 1'b0)
    `CHK(bad2, 1'b1)
    @(posedge core_clk);
    link2.port_select_n <= 1'b1;
    repeat (4) @(negedge core_clk);
    `CHK(link2.port_ready, 1'b1)
    $display("test select gating done");
    close_out();
  end
endmodule
`default_nettype wire

// file: src/hps_dev.sv
//Contract
//- One derived strobe times all transfers
//- Host holds select low while strobing
//- Strobes ignored while select high
//- Single low strobe: other input high
//- Single high strobe: other input low
//- Separate read/write strobes, one each input (here either input strobes; direction comes from read_not_write)
//- Ready low while busy, high when done
//- Ready forced high while select high
//- Select tied to strobe limits ready
//- Nonmux: bit0 picks control or data
//- Mux: two bits pick ctrl/inc/addr/data
//- Address strobe used only in mux
//- Mux: capture controls at address strobe
//- Unused address strobe held high
//- Irq pin follows CPU status bit
//- Strobe is XNOR of strobes, gated
//- Direction high read, low write
//- Byte enables: word, upper, lower, reserved
//- Nonmux: sample controls at strobe fall
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module hps_dev #(
  parameter int ACC_CYC = 4
) (
  // Clock and reset
  input  wire logic         CORE_CLK,
  input  wire logic         NRST,
  // Link
  hps_if.dev                LINK,
  // Configuration and CPU status
  input  wire logic         MUX_MODE,
  input  wire logic         CPU_STATUS3_DSP_TO_HOST_IRQ,
  // Access request to internal engine
  output logic              ACC_REQ,
  output hps_pkg::hps_sel_t ACC_SEL,
  output logic              ACC_INC,
  output logic              ACC_RNW,
  output logic [1:0]        ACC_BE_N,
  output logic              ACC_BE_BAD,
  input  wire logic         ACC_DONE
);
  import hps_pkg::*;

  logic       cs_s1_q, cs_s2_q, a_s1_q, a_s2_q, b_s1_q, b_s2_q, as_s1_q, as_s2_q;
  logic [4:0] lv_s1_q, lv_s2_q;
  logic       strb_q, as_q, busy_q, rdy_q;
  logic [1:0] ctl_lat_q, be_lat_q;
  logic       rnw_lat_q;
  logic       strb_n_d, strb_fall, as_fall;
  logic [1:0] ctl_use;
  logic [1:0] be_use;
  logic       rnw_use;

  // Two-flop synchronisers on every host pin
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      cs_s1_q <= 1'b1; cs_s2_q <= 1'b1;
      a_s1_q  <= 1'b1; a_s2_q  <= 1'b1;
      b_s1_q  <= 1'b1; b_s2_q  <= 1'b1;
      as_s1_q <= 1'b1; as_s2_q <= 1'b1;
      lv_s1_q <= 5'h00; lv_s2_q <= 5'h00;
    end else begin
      cs_s1_q <= LINK.port_select_n;   cs_s2_q <= cs_s1_q;
      a_s1_q  <= LINK.data_strobe_a_n; a_s2_q  <= a_s1_q;
      b_s1_q  <= LINK.data_strobe_b_n; b_s2_q  <= b_s1_q;
      as_s1_q <= LINK.addr_strobe_n;   as_s2_q <= as_s1_q;
      lv_s1_q <= {LINK.access_ctl, LINK.byte_enables_n, LINK.read_not_write};
      lv_s2_q <= lv_s1_q;
    end
  end

  // Active-low internal strobe; XNOR works for every polarity pairing
  assign strb_n_d  = cs_s2_q | (a_s2_q ~^ b_s2_q);
  assign strb_fall = strb_q & ~strb_n_d;
  // Address strobe is meaningless outside multiplexed mode
  assign as_fall   = MUX_MODE & as_q & ~as_s2_q;

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      strb_q <= 1'b1;
      as_q   <= 1'b1;
    end else begin
      strb_q <= strb_n_d;
      as_q   <= as_s2_q;
    end
  end

  // Mux mode latches controls at address strobe so host may drop them early
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      ctl_lat_q <= 2'h0;
      be_lat_q  <= HPS_BE_WORD;
      rnw_lat_q <= 1'b1;
    end else if (as_fall) begin
      ctl_lat_q <= lv_s2_q[4:3];
      be_lat_q  <= lv_s2_q[2:1];
      rnw_lat_q <= lv_s2_q[0];
    end
  end

  // In mux mode, live levels are used only in the cycle the address strobe rises; otherwise the latched ones
  always_comb begin
    if (MUX_MODE && as_s2_q && !as_q) begin
      ctl_use = lv_s2_q[4:3];
      be_use  = lv_s2_q[2:1];
      rnw_use = lv_s2_q[0];
    end else if (MUX_MODE) begin
      ctl_use = ctl_lat_q;
      be_use  = be_lat_q;
      rnw_use = rnw_lat_q;
    end else begin
      ctl_use = lv_s2_q[4:3];
      be_use  = lv_s2_q[2:1];
      rnw_use = lv_s2_q[0];
    end
  end

  // Sample cycle type on the strobe fall and launch one access
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      ACC_REQ    <= 1'b0;
      ACC_SEL    <= HPS_SEL_CTRL;
      ACC_INC    <= 1'b0;
      ACC_RNW    <= 1'b1;
      ACC_BE_N   <= HPS_BE_WORD;
      ACC_BE_BAD <= 1'b0;
    end else begin
      ACC_REQ <= strb_fall & ~busy_q;
      if (strb_fall && !busy_q) begin
        ACC_SEL    <= hps_decode(MUX_MODE, ctl_use);
        ACC_INC    <= MUX_MODE & (ctl_use == HPS_ACC_DATA_INC);
        ACC_RNW    <= rnw_use;
        ACC_BE_N   <= be_use;
        ACC_BE_BAD <= (be_use == HPS_BE_RSVD);
      end
    end
  end

  // Busy from strobe detection to completion of the internal access
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) busy_q <= 1'b0;
    else if (strb_fall) busy_q <= 1'b1;
    else if (ACC_DONE) busy_q <= 1'b0;
  end

  // Ready: low while busy, high when deselected regardless of state
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) rdy_q <= HPS_RDY_RST;
    else       rdy_q <= cs_s2_q | ~(busy_q | strb_fall);
  end
  assign LINK.port_ready = rdy_q;

  // Interrupt pin follows the CPU status bit; software toggles it to pulse
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) LINK.dsp_to_host_irq <= HPS_IRQ_RST;
    else       LINK.dsp_to_host_irq <= CPU_STATUS3_DSP_TO_HOST_IRQ;
  end
endmodule
`default_nettype wire

// file: src/hps_host.sv
`timescale 1ns/100ps
`default_nettype none
module hps_host #(
  parameter int STROBE_CYC = hps_pkg::HPS_HOST_STROBE_CYC
) (
  // Clock and reset
  input  wire logic       CORE_CLK,
  input  wire logic       NRST,
  // Link
  hps_if.host             LINK,
  // User request
  input  wire logic       REQ,
  input  wire logic [1:0] CTL,
  input  wire logic [1:0] BE_N,
  input  wire logic       RNW,
  input  wire logic       MUX_MODE,
  // User status
  output logic            BUSY,
  output logic            DONE,
  output logic            IRQ
);
  import hps_pkg::*;

  typedef enum logic [2:0] {H_IDLE, H_ALE, H_STRB, H_WAIT, H_END} hps_hst_t;

  hps_hst_t   st_q;
  logic [7:0] cnt_q;
  logic       rdy_s1_q, rdy_s2_q, irq_s1_q, irq_s2_q;

  // Link inputs are asynchronous to this host
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      rdy_s1_q <= 1'b0;
      rdy_s2_q <= 1'b0;
      irq_s1_q <= 1'b0;
      irq_s2_q <= 1'b0;
    end else begin
      rdy_s1_q <= LINK.port_ready;
      rdy_s2_q <= rdy_s1_q;
      irq_s1_q <= LINK.dsp_to_host_irq;
      irq_s2_q <= irq_s1_q;
    end
  end

  // Single active-low strobe on input a, input b held high
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      st_q                 <= H_IDLE;
      cnt_q                <= 8'h00;
      LINK.port_select_n   <= 1'b1;
      LINK.data_strobe_a_n <= 1'b1;
      LINK.data_strobe_b_n <= 1'b1;
      LINK.addr_strobe_n   <= 1'b1;
      LINK.access_ctl      <= 2'h0;
      LINK.byte_enables_n  <= HPS_BE_WORD;
      LINK.read_not_write  <= 1'b1;
      BUSY                 <= 1'b0;
      DONE                 <= 1'b0;
    end else begin
      DONE <= 1'b0;
      case (st_q)
        H_IDLE: begin
          if (REQ) begin
            LINK.port_select_n  <= 1'b0;
            LINK.access_ctl     <= CTL;
            LINK.byte_enables_n <= (BE_N == HPS_BE_RSVD) ? HPS_BE_WORD : BE_N;
            LINK.read_not_write <= RNW;
            LINK.addr_strobe_n  <= ~MUX_MODE;
            BUSY                <= 1'b1;
            st_q                <= MUX_MODE ? H_ALE : H_STRB;
          end
        end
        H_ALE: begin
          LINK.addr_strobe_n <= 1'b1;
          st_q               <= H_STRB;
        end
        H_STRB: begin
          LINK.data_strobe_a_n <= 1'b0;
          cnt_q                <= 8'h00;
          st_q                 <= H_WAIT;
        end
        H_WAIT: begin
          // Hold strobe at least the width and until ready comes back
          if (cnt_q != 8'(STROBE_CYC)) begin
            cnt_q <= cnt_q + 8'h01;
          end else if (rdy_s2_q) begin
            LINK.data_strobe_a_n <= 1'b1;
            st_q                 <= H_END;
          end
        end
        H_END: begin
          LINK.port_select_n <= 1'b1;
          BUSY               <= 1'b0;
          DONE               <= 1'b1;
          st_q               <= H_IDLE;
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  // Interrupt level from the device
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) IRQ <= 1'b0;
    else       IRQ <= irq_s2_q;
  end
endmodule
`default_nettype wire

// file: src/hps_if.sv
`timescale 1ns/100ps
`default_nettype none
interface hps_if;
  logic       port_select_n;
  logic       data_strobe_a_n;
  logic       data_strobe_b_n;
  logic       addr_strobe_n;
  logic [1:0] access_ctl;
  logic [1:0] byte_enables_n;
  logic       read_not_write;
  logic       port_ready;
  logic       dsp_to_host_irq;

  modport dev (
    input  port_select_n, data_strobe_a_n, data_strobe_b_n, addr_strobe_n,
    input  access_ctl, byte_enables_n, read_not_write,
    output port_ready, dsp_to_host_irq
  );
  modport host (
    output port_select_n, data_strobe_a_n, data_strobe_b_n, addr_strobe_n,
    output access_ctl, byte_enables_n, read_not_write,
    input  port_ready, dsp_to_host_irq
  );
endinterface
`default_nettype wire

// file: src/hps_pkg.sv
package hps_pkg;
  // Access-control decode values
  localparam logic [1:0] HPS_ACC_CTRL     = 2'h0;
  localparam logic [1:0] HPS_ACC_DATA_INC = 2'h1;
  localparam logic [1:0] HPS_ACC_ADDR     = 2'h2;
  localparam logic [1:0] HPS_ACC_DATA     = 2'h3;
  // Byte-enable encodings (active low)
  localparam logic [1:0] HPS_BE_WORD  = 2'h0;
  localparam logic [1:0] HPS_BE_UPPER = 2'h1;
  localparam logic [1:0] HPS_BE_LOWER = 2'h2;
  localparam logic [1:0] HPS_BE_RSVD  = 2'h3;
  // Reset values
  localparam logic       HPS_RDY_RST  = 1'b1;
  localparam logic       HPS_IRQ_RST  = 1'b0;
  // Host strobe count; minimum strobe width is this plus one clock cycle
  localparam int         HPS_HOST_STROBE_CYC = 8;

  typedef enum logic [1:0] {
    HPS_SEL_CTRL,
    HPS_SEL_ADDR,
    HPS_SEL_DATA
  } hps_sel_t;

  // Decode access control; mux selects two-bit meaning, else bit 0 only
  function automatic hps_sel_t hps_decode(input logic mux, input logic [1:0] ctl);
    hps_sel_t s;
    s = HPS_SEL_CTRL;
    if (!mux) begin
      s = ctl[0] ? HPS_SEL_DATA : HPS_SEL_CTRL;
    end else begin
      case (ctl)
        HPS_ACC_CTRL: s = HPS_SEL_CTRL;
        HPS_ACC_ADDR: s = HPS_SEL_ADDR;
        default:      s = HPS_SEL_DATA;
      endcase
    end
    return s;
  endfunction
endpackage
